/* design/ced_pkg.sv */
// Package for the exception prioritiser and dispatcher: codes, vectors, carriers
// Behaviour
// (RULE1) Disabled coprocessor: general vector, CU+level, 0x0B
// (RULE2) Reserved instruction: general vector, level, code 0x0A
// (RULE3) Arithmetic overflow: general vector, level, code 0x0C
// (RULE4) True trap: general vector, level, code 0x0D
// (RULE5) Misaligned store: general vector, level, code 0x05
// (RULE6) Data bus error: general vector, level, code 0x07
// (RULE7) Load data break: probe-selected vector, load bit
// (RULE8) Store data break: same vectors, store bit
// (RULE9) Complex break: debug vector, imprecise bits, no code
// (RULE10) Fixed descending priority among pending conditions
package ced_pkg;

    localparam logic [31:0] GEN_VEC_OFFSET = 32'h0000_0180;
    localparam logic [31:0] DBG_VEC_NOPROBE = 32'hbfc0_0480;
    localparam logic [31:0] DBG_VEC_PROBE = 32'hbfc0_0200;

    localparam logic [4:0] CODE_COP_UNUSABLE = 5'h0b;
    localparam logic [4:0] CODE_RESERVED = 5'h0a;
    localparam logic [4:0] CODE_OVERFLOW = 5'h0c;
    localparam logic [4:0] CODE_TRAP = 5'h0d;
    localparam logic [4:0] CODE_STORE_MISALIGN = 5'h05;
    localparam logic [4:0] CODE_BUS_ERROR = 5'h07;
    localparam logic [4:0] CODE_RESET = 5'h00;
    localparam logic [31:0] VEC_RESET = 32'h0000_0000;

    // Condition bits, highest priority in the top bit
    typedef struct packed {
        logic cop_unusable;
        logic reserved_instr_exc;
        logic arith_overflow_exc;
        logic trap_exc;
        logic load_data_break;
        logic store_data_break;
        logic store_misalign_exc;
        logic data_bus_error_exc;
        logic complex_break;
    } ced_cond_t;

    // One request from the pipeline, valid for the cycle it is shown
    typedef struct packed {
        ced_cond_t cond;
        logic [1:0] cop_num;
        logic [2:0] complex_break_kind;
    } ced_req_t;

    // Debug bits: complex-break kinds are instr, load, store (bits 2..0)
    typedef struct packed {
        logic load_data_break;
        logic store_data_break;
        logic instr_break_imprecise;
        logic load_break_imprecise;
        logic store_break_imprecise;
    } ced_dbg_t;

    typedef struct packed {
        logic [31:0] vector;
        logic [4:0] code;
        logic is_debug;
    } ced_disp_t;

    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_COP = 4'h1,
        SEL_RI = 4'h2,
        SEL_OV = 4'h3,
        SEL_TRAP = 4'h4,
        SEL_DBL = 4'h5,
        SEL_DBS = 4'h6,
        SEL_STORE_MISALIGN_EXC = 4'h7,
        SEL_DBE = 4'h8,
        SEL_COMPLEX_BREAK = 4'h9
    } ced_sel_t;

endpackage : ced_pkg

/* design/ced_dispatch.sv */
// Exception prioritiser and dispatcher for the lower-priority fault and break rows
`timescale 1ns/1ns
module ced_dispatch #(
    parameter int XLEN = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Pipeline request
    input wire ced_pkg::ced_req_t req,
    input wire logic [31:0] exception_vector_base,
    input wire logic probe_enable_bit,
    // Return from handlers
    input wire logic exl_clear,
    input wire logic debug_clear,
    // Dispatch result
    output logic disp_valid,
    output ced_pkg::ced_disp_t disp,
    // Status and debug state
    output logic exception_level_bit,
    output logic [3:0] coproc_usable_bits,
    output logic [4:0] exception_cause_code,
    output ced_pkg::ced_dbg_t debug_bits
);
    import ced_pkg::*;

    // Refuse a core width that the vector and code logic cannot serve
    if (XLEN != 32) begin : g_bad_xlen
        $error("ced_dispatch serves only a 32-bit core");
    end

    // Highest pending condition wins
    function automatic ced_sel_t pick(input ced_cond_t c);
        ced_sel_t s;
        s = SEL_NONE;
        if (c.cop_unusable) begin
            s = SEL_COP;
        end else if (c.reserved_instr_exc) begin
            s = SEL_RI;
        end else if (c.arith_overflow_exc) begin
            s = SEL_OV;
        end else if (c.trap_exc) begin
            s = SEL_TRAP;
        end else if (c.load_data_break) begin
            s = SEL_DBL;
        end else if (c.store_data_break) begin
            s = SEL_DBS;
        end else if (c.store_misalign_exc) begin
            s = SEL_STORE_MISALIGN_EXC;
        end else if (c.data_bus_error_exc) begin
            s = SEL_DBE;
        end else if (c.complex_break) begin
            s = SEL_COMPLEX_BREAK;
        end
        return s;
    endfunction : pick

    ced_sel_t sel;
    logic [31:0] gen_vec;
    logic [31:0] dbg_vec;
    logic is_gen;
    logic is_dbg;
    logic [4:0] next_code;
    ced_dbg_t dbg_set;
    logic [3:0] cu_set;

    assign sel = pick(req.cond); // RULE10
    assign gen_vec = exception_vector_base + GEN_VEC_OFFSET;
    assign dbg_vec = probe_enable_bit ? DBG_VEC_PROBE : DBG_VEC_NOPROBE; // RULE7

    always_comb begin
        next_code = CODE_RESET;
        is_gen = 1'b1;
        dbg_set = '0;
        cu_set = 4'h0;
        unique case (sel)
            SEL_NONE: begin
                is_gen = 1'b0;
            end
            SEL_COP: begin
                next_code = CODE_COP_UNUSABLE; // RULE1
                cu_set[req.cop_num] = 1'b1; // RULE1
            end
            SEL_RI: begin
                next_code = CODE_RESERVED; // RULE2
            end
            SEL_OV: begin
                next_code = CODE_OVERFLOW; // RULE3
            end
            SEL_TRAP: begin
                next_code = CODE_TRAP; // RULE4
            end
            SEL_STORE_MISALIGN_EXC: begin
                next_code = CODE_STORE_MISALIGN; // RULE5
            end
            SEL_DBE: begin
                next_code = CODE_BUS_ERROR; // RULE6
            end
            SEL_DBL: begin
                is_gen = 1'b0;
                dbg_set.load_data_break = 1'b1; // RULE7
            end
            SEL_DBS: begin
                is_gen = 1'b0;
                dbg_set.store_data_break = 1'b1; // RULE8
            end
            SEL_COMPLEX_BREAK: begin
                is_gen = 1'b0;
                // A break with no kind given counts as an instruction break
                dbg_set.instr_break_imprecise = req.complex_break_kind[2] || (req.complex_break_kind == 3'h0); // RULE9
                dbg_set.load_break_imprecise = req.complex_break_kind[1]; // RULE9
                dbg_set.store_break_imprecise = req.complex_break_kind[0]; // RULE9
            end
            default: begin
                is_gen = 1'b0;
            end
        endcase
    end

    assign is_dbg = (sel == SEL_DBL) || (sel == SEL_DBS) || (sel == SEL_COMPLEX_BREAK);

    // Dispatch result, one cycle after the request
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            disp_valid <= 1'b0;
            disp <= '{vector: VEC_RESET, code: CODE_RESET, is_debug: 1'b0};
        end else begin
            disp_valid <= is_gen || is_dbg;
            if (is_gen) begin
                disp <= '{vector: gen_vec, code: next_code, is_debug: 1'b0}; // RULE1 RULE2 RULE3
            end else if (is_dbg) begin
                disp <= '{vector: dbg_vec, code: CODE_RESET, is_debug: 1'b1}; // RULE8 RULE9
            end
        end
    end

    // Exception level: a new exception wins over a return in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            exception_level_bit <= 1'b0;
        end else if (is_gen) begin
            exception_level_bit <= 1'b1; // RULE4 RULE5 RULE6
        end else if (exl_clear) begin
            exception_level_bit <= 1'b0;
        end
    end

    // Cause code and unusable coprocessor, written only by general exceptions
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            exception_cause_code <= CODE_RESET;
            coproc_usable_bits <= 4'h0;
        end else if (is_gen) begin
            exception_cause_code <= next_code;
            coproc_usable_bits <= cu_set; // RULE1
        end
    end

    // Debug bits: held until the next debug event replaces them or a debug return clears them, set wins over a debug return
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            debug_bits <= '0;
        end else if (is_dbg) begin
            debug_bits <= dbg_set; // RULE7 RULE8 RULE9
        end else if (debug_clear) begin
            debug_bits <= '0;
        end
    end

endmodule : ced_dispatch

/* tb/ced_properties.sv */
// Concurrent checks on the dispatcher ports
`timescale 1ns/1ns
module ced_properties (
    // Clock, reset and single-bit signals
    input wire logic core_clk, arst_n, probe_enable_bit, exl_clear, debug_clear,
    input wire logic disp_valid, exception_level_bit,
    // Buses
    input wire ced_pkg::ced_req_t req,
    input wire logic [31:0] exception_vector_base,
    input wire ced_pkg::ced_disp_t disp,
    input wire logic [3:0] coproc_usable_bits,
    input wire logic [4:0] exception_cause_code,
    input wire ced_pkg::ced_dbg_t debug_bits
);
    import ced_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    property p_gen(m, c);
        m |=> disp_valid && disp.code == c && exception_cause_code == c && exception_level_bit
            && disp.vector == $past(exception_vector_base) + GEN_VEC_OFFSET;
    endproperty
    property p_dbg(m, d);
        m |=> disp.is_debug && debug_bits == d && $stable(exception_cause_code)
            && disp.vector == ($past(probe_enable_bit) ? DBG_VEC_PROBE : DBG_VEC_NOPROBE);
    endproperty
    AST_COP: assert property (req.cond[8] |=> exception_level_bit
        && coproc_usable_bits == (4'h1 << $past(req.cop_num)))
        else $error("bad cu");
    AST_RI: assert property (p_gen(req.cond[8:7] == 2'b01, CODE_RESERVED))
        else $error("bad ri");
    AST_OV: assert property (p_gen(req.cond[8:6] == 3'b001, CODE_OVERFLOW))
        else $error("bad ov");
    AST_TRAP: assert property (p_gen(req.cond[8:5] == 4'h1, CODE_TRAP))
        else $error("bad trap");
    AST_STORE_MISALIGN_EXC: assert property (p_gen(req.cond[8:2] == 7'h01, CODE_STORE_MISALIGN))
        else $error("bad misalign");
    AST_DBE: assert property (p_gen(req.cond[8:1] == 8'h01, CODE_BUS_ERROR))
        else $error("bad bus error");
    AST_DBL: assert property (p_dbg(req.cond[8:4] == 5'h01, 5'h10))
        else $error("bad load break");
    AST_DBS: assert property (p_dbg(req.cond[8:3] == 6'h01, 5'h08))
        else $error("bad store break");
    AST_COMPLEX_BREAK: assert property (req.cond == 9'h001 |=> disp.is_debug
        && debug_bits == {2'b00, ($past(req.complex_break_kind) == 3'h0 ? 3'b100 : $past(req.complex_break_kind))})
        else $error("bad complex break");
    COV_ALL: cover property (req.cond == 9'h1ff);
    COV_DBG: cover property (disp_valid && disp.is_debug);
    COV_CLR: cover property (exl_clear && exception_level_bit);
endmodule : ced_properties
bind ced_dispatch ced_properties u_props (.*);

/* tb/ced_pipe_model.sv */
// Pipeline stand-in that presents requests on the falling edge
`timescale 1ns/1ns
module ced_pipe_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Requests
    input wire ced_pkg::ced_req_t cmd,
    output ced_pkg::ced_req_t req
);
    import ced_pkg::*;
    always_ff @(negedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            req <= '0;
        end else begin
            req <= cmd;
        end
    end
endmodule : ced_pipe_model

/* tb/cpu_exception_dispatch_tail_tb_top.sv */
// Self-checking bench for the exception dispatcher
`timescale 1ns/1ns
module cpu_exception_dispatch_tail_tb_top;
    import ced_pkg::*;
    typedef struct packed {
        logic [8:0] c;
        logic [1:0] n;
        logic [2:0] k;
        logic p;
        logic [4:0] x;
        logic [4:0] d;
    } ced_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic probe_enable_bit = 1'b0;
    logic exl_clear = 1'b0;
    logic debug_clear = 1'b0;
    logic [31:0] exception_vector_base = 32'h1d00_0000;
    ced_req_t cmd = '0;
    ced_req_t req;
    logic disp_valid;
    ced_disp_t disp;
    logic exception_level_bit;
    logic [3:0] coproc_usable_bits;
    logic [4:0] exception_cause_code;
    ced_dbg_t debug_bits;
    logic [4:0] lc = 5'h00;
    logic [4:0] ld = 5'h00;
    int n_fail = 0;
    int comparisons = 0;
    ced_row_t rows [10] = '{'{9'h1ff, 2, 0, 0, 5'h0b, 0}, '{9'h0ff, 0, 0, 0, 5'h0a, 0},
        '{9'h07f, 0, 0, 0, 5'h0c, 0}, '{9'h03f, 0, 0, 0, 5'h0d, 0}, '{9'h01f, 0, 0, 1, 0, 5'h10},
        '{9'h00f, 0, 0, 0, 0, 5'h08}, '{9'h007, 0, 0, 0, 5'h05, 0}, '{9'h003, 0, 0, 0, 5'h07, 0},
        '{9'h001, 0, 0, 1, 0, 5'h04}, '{9'h001, 0, 3, 0, 0, 5'h03}};
    always #5 core_clk = ~core_clk;
    ced_pipe_model pipe (.*);
    ced_dispatch dut (.*);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic go(input ced_req_t r);
        @(posedge core_clk);
        cmd <= r;
        @(negedge core_clk);
    endtask : go
    task automatic tally_and_finish;
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(negedge core_clk);
        arst_n = 1'b1;
        chk({disp_valid, disp, exception_level_bit, coproc_usable_bits, debug_bits}, 64'h0);
        foreach (rows[i]) begin
            probe_enable_bit = rows[i].p;
            go('{rows[i].c, rows[i].n, rows[i].k});
            go('0);
            lc = rows[i].x != 5'h00 ? rows[i].x : lc;
            ld = rows[i].x == 5'h00 ? rows[i].d : ld;
            chk({disp_valid, disp, exception_level_bit, exception_cause_code, debug_bits,
                coproc_usable_bits}, {1'b1, (rows[i].x != 5'h00 ? exception_vector_base
                + GEN_VEC_OFFSET : rows[i].p ? DBG_VEC_PROBE : DBG_VEC_NOPROBE), rows[i].x,
                rows[i].x == 5'h00, 1'b1, lc, ld, (rows[i].c[8] ? 4'h4 : 4'h0)});
        end
        go('0);
        chk(disp_valid, 1'b0);
        // Back to back, wrapping base, clears racing a new dispatch
        exception_vector_base = 32'hffff_ff00;
        exl_clear = 1'b1;
        probe_enable_bit = 1'b0;
        go('{9'h020, 2'h0, 3'h0});
        go('{9'h010, 2'h0, 3'h0});
        chk({disp, exception_level_bit}, {32'h0000_0080, CODE_TRAP, 2'b01});
        debug_clear = 1'b1;
        go('0);
        chk({disp, debug_bits, exception_level_bit}, {DBG_VEC_NOPROBE, 6'h01, 6'h20});
        go('0);
        chk({debug_bits, exception_cause_code}, {5'h00, CODE_TRAP});
        tally_and_finish();
    end
endmodule : cpu_exception_dispatch_tail_tb_top
